// ---- pkg/rail_seq_defines.svh ----
// named constants for the dual-rail phase sequencer: register offsets,
// field positions, reset values and timing figures.
// assumes it is included by bare name into the package and the design.
`ifndef RAIL_SEQ_DEFINES_SVH
`define RAIL_SEQ_DEFINES_SVH

`define MCLK_PERIOD_NS 5
`define INIT_BASE_NS 200000
`define INIT_UNIT_NS 1000
`define VID_STEP_TIME_NS 25

`define REG_RAIL_EN 8'h20
`define REG_PHASE_MAP 8'hca
`define REG_VID_STEP 8'he4
`define REG_BUS_ADDR 8'hf8
`define REG_SW_PERIOD 8'hfc
`define REG_SET_VID 8'hd0
`define REG_INIT_DLY 8'hd1
`define REG_BOOT_VID 8'hd2
`define REG_PSTATE 8'hd3
`define REG_STATUS 8'hd4
`define REG_IOUT 8'h8c

`define RAIL_A_BIT 0
`define RAIL_B_BIT 1
`define VID_STEP_BIT 0
`define ADDR_USE_REG_BIT 7
`define ADDR_HI_MSB 6
`define ADDR_HI_LSB 4
`define SWP_MSB 15
`define SWP_LSB 8
`define IOUT_FULL 8'hff
`define CFG_RESET 8'h00
`define PERIOD_RESET 16'h0000
`define PHASE_COUNT 6

`endif

// ---- pkg/rail_seq_pkg.sv ----
// types shared by the phase sequencer and its surroundings.
// assumes rail_seq_defines.svh is on the include path.
`include "rail_seq_defines.svh"

package rail_seq_pkg;

    typedef enum logic [2:0] {
        seq_load,
        seq_init,
        seq_wait_vid,
        seq_ramp,
        seq_run
    } seq_type;

    typedef enum logic [1:0] {
        state_full,
        state_single,
        state_light
    } pstate_type;

    // configuration image held in the nonvolatile store
    typedef struct packed {
        logic [7:0] rail_en;
        logic [7:0] phase_map;
        logic [7:0] vid_step;
        logic [7:0] bus_addr;
        logic [15:0] sw_period;
        logic [7:0] init_dly;
        logic [7:0] boot_vid;
    } nv_cfg_type;

    // decoded command from the serial bus front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic valid;
        logic [5:0] rail_a;
        logic [5:0] rail_b;
    } phase_map_type;

endpackage : rail_seq_pkg

// ---- design/rail_phase_sequencer.sv ----
// dual-rail multiphase controller core: phase mapping, bus address,
// start-up sequencing, power-state gating, reference and current report.
// assumes a bus front end that decodes commands into reg_req_i on mclk_i,
// a nonvolatile image valid at reset release, and an address-strap decoder.
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defines.svh"

module rail_phase_sequencer #(
    parameter int INIT_BASE_CYCLES = `INIT_BASE_NS / `MCLK_PERIOD_NS,
    parameter logic [9:0] CURRENT_MONITOR_OUT_FULL_CODE = 10'h3ff
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire rail_seq_pkg::reg_req_type reg_req_i,
    output logic [15:0] reg_rdata_o,
    input wire rail_seq_pkg::nv_cfg_type nv_cfg_i,
    input wire logic [2:0] strap_code_i,
    input wire logic [7:0] duty_i,
    input wire logic [9:0] adc_code_i,
    input wire logic adc_valid_i,
    output logic [6:0] bus_address_o,
    output logic [5:0] pwm_o,
    output logic [5:0] pwm_oe_o,
    output logic [1:0] dcm_o,
    output logic [9:0] ref_code_o,
    output logic regulator_ready_out
);

    localparam int UNIT_CYCLES = `INIT_UNIT_NS / `MCLK_PERIOD_NS;
    localparam int SLEW_CYCLES = `VID_STEP_TIME_NS / `MCLK_PERIOD_NS;

    typedef struct packed {
        rail_seq_pkg::seq_type seq;
        logic [17:0] timer;
        logic [7:0] rail_en;
        logic [7:0] phase_map;
        logic [7:0] vid_step;
        logic [7:0] addr_cfg;
        logic [15:0] sw_period;
        logic [7:0] init_dly;
        logic [7:0] boot_vid;
        logic [7:0] target_vid;
        logic [7:0] ref_vid;
        logic [1:0] pstate;
        logic [7:0] iout;
        logic [2:0] slew_cnt;
        logic [8:0] cnt_a;
        logic [8:0] cnt_b;
        logic [2:0] strap_s1;
        logic [2:0] strap_s2;
        logic [6:0] bus_addr;
        logic [5:0] pwm;
        logic [5:0] oe;
        logic [1:0] dcm;
        logic [9:0] ref_code;
        logic ready;
        logic [15:0] rdata;
    } state_type;

    state_type q;
    state_type d;

    // phase assignment per code; rail B only ever takes pins 4..6
    function automatic rail_seq_pkg::phase_map_type decode_map(input logic [3:0] code);
        rail_seq_pkg::phase_map_type m;
        m = '{valid: 1'b1, rail_a: 6'h00, rail_b: 6'h00};
        case (code)
            4'h0: m.rail_a = 6'h3f;
            4'h1: m.rail_a = 6'h1f;
            4'h2: begin m.rail_a = 6'h1f; m.rail_b = 6'h20; end
            4'h3: m.rail_a = 6'h0f;
            4'h4: begin m.rail_a = 6'h0f; m.rail_b = 6'h20; end
            4'h5: begin m.rail_a = 6'h0f; m.rail_b = 6'h30; end
            4'h6: m.rail_a = 6'h07;
            4'h7: begin m.rail_a = 6'h07; m.rail_b = 6'h20; end
            4'h8: begin m.rail_a = 6'h07; m.rail_b = 6'h30; end
            4'h9: begin m.rail_a = 6'h07; m.rail_b = 6'h38; end
            4'ha: m.rail_a = 6'h03;
            4'hb: begin m.rail_a = 6'h03; m.rail_b = 6'h20; end
            4'hc: begin m.rail_a = 6'h03; m.rail_b = 6'h30; end
            4'hd: m.rail_a = 6'h01;
            4'he: begin m.rail_a = 6'h01; m.rail_b = 6'h20; end
            default: m.valid = 1'b0;
        endcase
        return m;
    endfunction : decode_map

    // phase k of n starts k/n of the way into the rail period
    function automatic logic phase_hit(input logic [8:0] cnt, input logic [8:0] per,
                                       input logic [2:0] k, input logic [2:0] n,
                                       input logic [7:0] duty);
        logic [11:0] prod;
        logic [8:0] start;
        logic [9:0] rel;
        prod = 12'(per) * 12'(k);
        start = (n == 3'h0) ? 9'h000 : 9'(prod / 12'(n));
        rel = (cnt >= start) ? 10'(cnt - start) : 10'({1'b0, cnt} + {1'b0, per} - {1'b0, start});
        return (per != 9'h000) && (rel < 10'(duty));
    endfunction : phase_hit

    function automatic logic [5:0] lowest_only(input logic [5:0] m);
        return m & (~m + 6'h01);
    endfunction : lowest_only

    rail_seq_pkg::phase_map_type map;
    logic [5:0] act_a;
    logic [5:0] act_b;
    logic [8:0] per_a;
    logic [8:0] per_b;
    logic [2:0] ka;
    logic [2:0] kb;
    logic [2:0] na;
    logic [2:0] nb;
    logic dynamic_voltage_transition;
    logic reduced;
    logic light;
    logic running;
    logic [5:0] hit;
    logic [17:0] scaled;

    always_comb begin
        d = q;
        map = decode_map(q.phase_map[3:0]);
        dynamic_voltage_transition = (q.seq == rail_seq_pkg::seq_run) && (q.ref_vid != q.target_vid);
        running = (q.seq == rail_seq_pkg::seq_ramp) || (q.seq == rail_seq_pkg::seq_run);
        reduced = !dynamic_voltage_transition && (q.pstate == 2'(rail_seq_pkg::state_single) ||
                            q.pstate == 2'(rail_seq_pkg::state_light));
        light = !dynamic_voltage_transition && (q.pstate == 2'(rail_seq_pkg::state_light));
        act_a = (map.valid && q.rail_en[`RAIL_A_BIT]) ? map.rail_a : 6'h00;
        act_b = (map.valid && q.rail_en[`RAIL_B_BIT]) ? map.rail_b : 6'h00;
        if (reduced) begin
            act_a = lowest_only(act_a);
            act_b = lowest_only(act_b);
        end
        // light load stretches the period so each pulse spaces out
        per_a = {1'b0, q.sw_period[`SWP_MSB:`SWP_LSB]};
        if (light) begin
            per_a = {q.sw_period[`SWP_MSB:`SWP_LSB], 1'b0};
        end
        per_b = per_a;
        na = 3'($countones(act_a));
        nb = 3'($countones(act_b));
        ka = 3'h0;
        kb = 3'h0;
        hit = 6'h00;
        for (int i = 0; i < `PHASE_COUNT; i++) begin
            if (act_a[i]) begin
                hit[i] = phase_hit(q.cnt_a, per_a, ka, na, duty_i);
                ka = ka + 3'h1;
            end
            if (act_b[i]) begin
                hit[i] = phase_hit(q.cnt_b, per_b, kb, nb, duty_i);
                kb = kb + 3'h1;
            end
        end
        d.cnt_a = (9'(q.cnt_a + 9'h001) >= per_a) ? 9'h000 : 9'(q.cnt_a + 9'h001);
        d.cnt_b = (9'(q.cnt_b + 9'h001) >= per_b) ? 9'h000 : 9'(q.cnt_b + 9'h001);
        // map changes land here directly, nothing else needs reprogramming
        d.oe = running ? (act_a | act_b) : 6'h00;
        d.pwm = d.oe & hit;
        d.dcm = {light && running && act_b != 6'h00, light && running && act_a != 6'h00};
        d.ref_code = q.vid_step[`VID_STEP_BIT] ? {1'b0, q.ref_vid, 1'b0}
                                               : {2'b00, q.ref_vid};

        d.strap_s1 = strap_code_i;
        d.strap_s2 = q.strap_s1;
        d.bus_addr = {q.addr_cfg[`ADDR_HI_MSB:`ADDR_HI_LSB],
                      q.addr_cfg[`ADDR_USE_REG_BIT] ? q.addr_cfg[3:0]
                                                    : {1'b0, q.strap_s2}};

        if (adc_valid_i) begin
            scaled = 18'(18'(adc_code_i) * 18'(`IOUT_FULL) / 18'(CURRENT_MONITOR_OUT_FULL_CODE));
            d.iout = (scaled > 18'(`IOUT_FULL)) ? `IOUT_FULL : scaled[7:0];
        end else begin
            scaled = 18'h00000;
        end

        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `REG_RAIL_EN: d.rail_en = reg_req_i.wdata[7:0];
                `REG_PHASE_MAP: d.phase_map = reg_req_i.wdata[7:0];
                `REG_VID_STEP: d.vid_step = reg_req_i.wdata[7:0];
                `REG_BUS_ADDR: d.addr_cfg = reg_req_i.wdata[7:0];
                `REG_SW_PERIOD: d.sw_period = reg_req_i.wdata;
                `REG_INIT_DLY: d.init_dly = reg_req_i.wdata[7:0];
                `REG_BOOT_VID: d.boot_vid = reg_req_i.wdata[7:0];
                `REG_PSTATE: d.pstate = reg_req_i.wdata[1:0];
                `REG_SET_VID: d.target_vid = reg_req_i.wdata[7:0];
                default: ;
            endcase
        end
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `REG_RAIL_EN: d.rdata = {8'h00, q.rail_en};
                `REG_PHASE_MAP: d.rdata = {8'h00, q.phase_map};
                `REG_VID_STEP: d.rdata = {8'h00, q.vid_step};
                `REG_BUS_ADDR: d.rdata = {8'h00, q.addr_cfg};
                `REG_SW_PERIOD: d.rdata = q.sw_period;
                `REG_INIT_DLY: d.rdata = {8'h00, q.init_dly};
                `REG_BOOT_VID: d.rdata = {8'h00, q.boot_vid};
                `REG_PSTATE: d.rdata = {14'h0000, q.pstate};
                `REG_SET_VID: d.rdata = {8'h00, q.target_vid};
                `REG_STATUS: d.rdata = {q.ref_vid, 3'h0, dynamic_voltage_transition, q.ready, q.seq};
                `REG_IOUT: d.rdata = {8'h00, q.iout};
                default: d.rdata = 16'h0000;
            endcase
        end

        if (running) begin
            if (q.slew_cnt == 3'(SLEW_CYCLES - 1)) begin
                d.slew_cnt = 3'h0;
                if (q.ref_vid < q.target_vid) begin
                    d.ref_vid = q.ref_vid + 8'h01;
                end else if (q.ref_vid > q.target_vid) begin
                    d.ref_vid = q.ref_vid - 8'h01;
                end
            end else begin
                d.slew_cnt = q.slew_cnt + 3'h1;
            end
        end

        unique case (q.seq)
            rail_seq_pkg::seq_load: begin
                d.rail_en = nv_cfg_i.rail_en;
                d.phase_map = nv_cfg_i.phase_map;
                d.vid_step = nv_cfg_i.vid_step;
                d.addr_cfg = nv_cfg_i.bus_addr;
                d.sw_period = nv_cfg_i.sw_period;
                d.init_dly = nv_cfg_i.init_dly;
                d.boot_vid = nv_cfg_i.boot_vid;
                d.timer = 18'(INIT_BASE_CYCLES) +
                          18'(18'(nv_cfg_i.init_dly) * 18'(UNIT_CYCLES));
                d.seq = rail_seq_pkg::seq_init;
            end
            rail_seq_pkg::seq_init: begin
                if (q.timer != 18'h00000) begin
                    d.timer = q.timer - 18'h00001;
                end else if (q.boot_vid == `CFG_RESET) begin
                    d.seq = rail_seq_pkg::seq_wait_vid;
                end else begin
                    d.target_vid = q.boot_vid;
                    d.slew_cnt = 3'h0;
                    d.seq = rail_seq_pkg::seq_ramp;
                end
            end
            rail_seq_pkg::seq_wait_vid: begin
                // only a non-zero target counts as a valid set-VOLTAGE_IDENTIFIER
                if (reg_req_i.wr && reg_req_i.addr == `REG_SET_VID &&
                    reg_req_i.wdata[7:0] != `CFG_RESET) begin
                    d.slew_cnt = 3'h0;
                    d.seq = rail_seq_pkg::seq_ramp;
                end
            end
            rail_seq_pkg::seq_ramp: begin
                if (q.ref_vid == q.target_vid) begin
                    d.ready = 1'b1;
                    d.seq = rail_seq_pkg::seq_run;
                end
            end
            rail_seq_pkg::seq_run: ;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.seq <= rail_seq_pkg::seq_load;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign bus_address_o = q.bus_addr;
    assign pwm_o = q.pwm;
    assign pwm_oe_o = q.oe;
    assign dcm_o = q.dcm;
    assign ref_code_o = q.ref_code;
    assign regulator_ready_out = q.ready;

    // helper: cycles spent in start-up delay
    logic [17:0] init_len_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            init_len_q <= 18'h00000;
        end else if (q.seq == rail_seq_pkg::seq_init) begin
            init_len_q <= init_len_q + 18'h00001;
        end else begin
            init_len_q <= 18'h00000;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_load;
        q.seq == rail_seq_pkg::seq_load;
    endsequence
    sequence s_init_done;
        q.seq == rail_seq_pkg::seq_init && q.timer == 18'h00000;
    endsequence

    property p_nv_load;
        s_load |=> q.phase_map == $past(nv_cfg_i.phase_map) && q.seq == rail_seq_pkg::seq_init;
    endproperty
    a_nv_load: assert property (p_nv_load) else $error("nv image not loaded");

    property p_init_len;
        s_init_done |-> init_len_q ==
            18'(INIT_BASE_CYCLES) + 18'(18'(q.init_dly) * 18'(UNIT_CYCLES));
    endproperty
    a_init_len: assert property (p_init_len) else $error("start-up delay wrong");

    property p_bad_map_hiz;
        !map.valid |=> pwm_oe_o == 6'h00;
    endproperty
    a_bad_map_hiz: assert property (p_bad_map_hiz) else $error("bad map drives pwm");

    property p_unassigned_hiz;
        1'b1 |=> (pwm_oe_o & ~($past(map.rail_a) | $past(map.rail_b))) == 6'h00;
    endproperty
    a_unassigned_hiz: assert property (p_unassigned_hiz) else $error("stray pwm");

    property p_rail_off;
        !q.rail_en[`RAIL_A_BIT] |=> ((pwm_o | pwm_oe_o) & $past(map.rail_a)) == 6'h00;
    endproperty
    a_rail_off: assert property (p_rail_off) else $error("disabled rail switches");

    property p_zero_boot;
        (q.seq == rail_seq_pkg::seq_wait_vid)[*2] |-> pwm_oe_o == 6'h00;
    endproperty
    a_zero_boot: assert property (p_zero_boot) else $error("pwm before set-vid");

    property p_ready;
        $rose(regulator_ready_out) |-> $past(q.ref_vid) == $past(q.target_vid);
    endproperty
    a_ready: assert property (p_ready) else $error("ready before target");

    property p_single;
        running && reduced |=> $countones(pwm_oe_o & $past(map.rail_a)) <= 1;
    endproperty
    a_single: assert property (p_single) else $error("more than one phase");

    property p_dynamic_voltage_transition_full;
        dynamic_voltage_transition |=> pwm_oe_o == $past(map.valid ? ((q.rail_en[`RAIL_A_BIT] ? map.rail_a : 6'h00) |
            (q.rail_en[`RAIL_B_BIT] ? map.rail_b : 6'h00)) : 6'h00);
    endproperty
    a_dynamic_voltage_transition_full: assert property (p_dynamic_voltage_transition_full) else $error("phases shed in dynamic_voltage_transition");

    property p_ref_scale;
        q.vid_step[`VID_STEP_BIT] ##1 $stable(q.ref_vid) |->
            ref_code_o == {1'b0, q.ref_vid, 1'b0};
    endproperty
    a_ref_scale: assert property (p_ref_scale) else $error("reference scale wrong");

    property p_addr;
        1'b1 |=> bus_address_o[6:4] == $past(q.addr_cfg[`ADDR_HI_MSB:`ADDR_HI_LSB]);
    endproperty
    a_addr: assert property (p_addr) else $error("address upper bits wrong");

    property p_iout_full;
        adc_valid_i && adc_code_i == CURRENT_MONITOR_OUT_FULL_CODE |=> q.iout == `IOUT_FULL;
    endproperty
    a_iout_full: assert property (p_iout_full) else $error("full scale not FFh");

endmodule : rail_phase_sequencer
`default_nettype wire

// ---- dv/power_stage_model.sv ----
// power stage model: resolves each pwm pin and measures its pulses.
// assumes pwm data and enable are registered on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    input wire logic mclk_i,
    input wire logic [5:0] pwm_i,
    input wire logic [5:0] pwm_oe_i,
    output var int rise_o [6],
    output var int per_o [6],
    output var int width_o [6]
);
    int cyc = 0;
    int hc [6];
    logic [5:0] prev = '0;
    wire [5:0] pin;
    // a floating pin never counts as on, whatever the data bit says
    for (genvar g = 0; g < 6; g++) begin : g_pin
        assign pin[g] = pwm_oe_i[g] ? pwm_i[g] : 1'bz;
    end
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 6; i++) begin
            prev[i] <= (pin[i] === 1'b1);
            if (pin[i] === 1'b1 && !prev[i]) begin
                rise_o[i] <= cyc;
                per_o[i] <= cyc - rise_o[i];
            end
            hc[i] <= (pin[i] === 1'b1) ? hc[i] + 1 : 0;
            if (pin[i] !== 1'b1 && prev[i]) width_o[i] <= hc[i];
        end
    end
endmodule : power_stage_model
`default_nettype wire

// ---- dv/tb_multiphase_rail_phase_sequencer.sv ----
// self-checking bench for the phase sequencer with a power stage model.
// assumes the design package and defines header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_multiphase_rail_phase_sequencer;
    localparam int INIT_CYC = 20;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    rail_seq_pkg::reg_req_type reg_req_i = '0;
    rail_seq_pkg::nv_cfg_type nv_cfg_i = '0;
    logic [2:0] strap_code_i = '0;
    logic [7:0] duty_i = 8'h03;
    logic [9:0] adc_code_i = '0;
    logic adc_valid_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic [6:0] bus_address_o;
    logic [5:0] pwm_o;
    logic [5:0] pwm_oe_o;
    logic [1:0] dcm_o;
    logic [9:0] ref_code_o;
    logic regulator_ready_out;
    int rise [6];
    int per [6];
    int width [6];
    int n_fail = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h297d;
    logic [15:0] exp_q [$];
    logic rd_d = 1'b0;
    logic [15:0] exp_v;
    logic [5:0] oe_tab [16] = '{6'h3f, 6'h1f, 6'h3f, 6'h0f, 6'h2f, 6'h3f, 6'h07, 6'h27,
        6'h37, 6'h3f, 6'h03, 6'h23, 6'h33, 6'h01, 6'h21, 6'h00};

    always #2.5 mclk_i = ~mclk_i;

    rail_phase_sequencer #(.INIT_BASE_CYCLES(INIT_CYC), .CURRENT_MONITOR_OUT_FULL_CODE(10'h3ff)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .nv_cfg_i(nv_cfg_i), .strap_code_i(strap_code_i), .duty_i(duty_i),
        .adc_code_i(adc_code_i), .adc_valid_i(adc_valid_i), .bus_address_o(bus_address_o),
        .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o), .dcm_o(dcm_o), .ref_code_o(ref_code_o),
        .regulator_ready_out(regulator_ready_out));

    power_stage_model i_stage (.mclk_i(mclk_i), .pwm_i(pwm_o), .pwm_oe_i(pwm_oe_o),
        .rise_o(rise), .per_o(per), .width_o(width));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    function automatic int md(input int x);
        return ((x % 12) + 12) % 12;
    endfunction : md

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        num_checks++;
        if (got !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc

    // one-cycle request pulse, then an idle cycle before the next
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        reg_req_i = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge mclk_i);
        reg_req_i = '0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask : rd

    task automatic do_reset(input rail_seq_pkg::nv_cfg_type nv);
        @(negedge mclk_i);
        rst_n_i = 1'b0;
        nv_cfg_i = nv;
        cyc(2);
        chk("pwm_oe_o in reset", 16'h0000, pwm_oe_o);
        chk("ready in reset", 16'h0000, regulator_ready_out);
        rst_n_i = 1'b1;
    endtask : do_reset

    task automatic wait_ready();
        for (int i = 0; i < 2000 && regulator_ready_out !== 1'b1; i++) @(negedge mclk_i);
        chk("regulator_ready_out", 16'h0001, regulator_ready_out);
    endtask : wait_ready

    // read data is registered on the edge that samples the request and checked at the next falling edge
    always @(posedge mclk_i) rd_d <= reg_req_i.rd;
    always @(negedge mclk_i) begin
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            chk("reg_rdata_o", exp_v, reg_rdata_o);
        end
    end

    initial begin : watchdog
        #100000;
        n_fail++;
        $display("[FAIL] watchdog expected done seen hang");
        summarize();
    end

    initial begin : main
        int t;
        logic [7:0] d;
        logic [5:0] acc;
        logic [9:0] a;
        logic [5:0] m;
        do_reset('{8'h03, 8'h09, 8'h00, 8'h20, 16'h0c55, 8'h01, 8'h04});
        t = 0;
        while (ref_code_o === 10'h000 && t < 400) begin
            @(negedge mclk_i);
            t++;
        end
        chk("start delay", 16'h0001, 16'(t >= INIT_CYC + 200 && t <= INIT_CYC + 210));
        wait_ready();
        chk("ref_code_o boot", 16'h0004, ref_code_o);
        chk("pwm_oe_o boot", 16'h003f, pwm_oe_o);
        rd(8'hca, 16'h0009);
        rd(8'hfc, 16'h0c55);
        $display("test startup done");
        seed = xs(seed);
        d = 8'(1 + seed % 10);
        duty_i = d;
        cyc(60);
        chk("pin1 period", 16'd12, 16'(per[0]));
        chk("pin1 width", 16'(d), 16'(width[0]));
        chk("pin2 offset", 16'd4, 16'(md(rise[1] - rise[0])));
        chk("pin3 offset", 16'd8, 16'(md(rise[2] - rise[0])));
        chk("pin5 offset", 16'd4, 16'(md(rise[4] - rise[3])));
        $display("test interleave done");
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, 8'hca, 16'(i));
            cyc(2);
            chk("pwm_oe_o map", 16'(oe_tab[i]), pwm_oe_o);
        end
        bus(1'b1, 8'hca, 16'h0009);
        $display("test phase map done");
        for (int i = 0; i < 4; i++) begin
            m = (i[0] ? 6'h07 : 6'h00) | (i[1] ? 6'h38 : 6'h00);
            bus(1'b1, 8'h20, 16'(i));
            cyc(2);
            acc = '0;
            repeat (24) begin
                @(negedge mclk_i);
                acc = acc | (pwm_o & pwm_oe_o);
            end
            chk("pwm_oe_o rail enable", 16'(m), pwm_oe_o);
            chk("pulses on disabled rail", 16'h0000, 16'(acc & ~m));
            chk("pulses on enabled rail", 16'(m), 16'(acc));
        end
        bus(1'b1, 8'h20, 16'h0003);
        rd(8'h20, 16'h0003);
        $display("test rail enable done");
        for (int ps = 0; ps < 4; ps++) begin
            bus(1'b1, 8'hd3, 16'(ps));
            cyc(60);
            chk("pwm_oe_o power state", (ps == 1 || ps == 2) ? 16'h0009 : 16'h003f, pwm_oe_o);
            chk("dcm_o", (ps == 2) ? 16'h0003 : 16'h0000, dcm_o);
            chk("pin1 period state", (ps == 2) ? 16'd24 : 16'd12, 16'(per[0]));
        end
        $display("test power state done");
        bus(1'b1, 8'hd3, 16'h0001);
        bus(1'b1, 8'hd0, 16'h0008);
        cyc(2);
        chk("pwm_oe_o transition", 16'h003f, pwm_oe_o);
        cyc(40);
        chk("pwm_oe_o settled", 16'h0009, pwm_oe_o);
        chk("ref_code_o target", 16'h0008, ref_code_o);
        bus(1'b1, 8'he4, 16'h0001);
        cyc(3);
        chk("ref_code_o 5mv", 16'h0010, ref_code_o);
        bus(1'b1, 8'he4, 16'h0000);
        cyc(3);
        chk("ref_code_o 2p5mv", 16'h0008, ref_code_o);
        bus(1'b1, 8'hd3, 16'h0000);
        $display("test transition done");
        for (int s = 0; s < 8; s++) begin
            strap_code_i = 3'(s);
            cyc(4);
            chk("bus_address_o strap", 16'(7'h20 + s), bus_address_o);
        end
        bus(1'b1, 8'hf8, 16'h00da);
        cyc(2);
        chk("bus_address_o register", 16'h005a, bus_address_o);
        rd(8'hf8, 16'h00da);
        bus(1'b1, 8'hf8, 16'h0030);
        cyc(2);
        chk("bus_address_o mixed", 16'h0037, bus_address_o);
        $display("test address done");
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            a = (k == 0) ? 10'h3ff : seed[9:0];
            @(negedge mclk_i);
            adc_code_i = a;
            adc_valid_i = 1'b1;
            @(negedge mclk_i);
            adc_valid_i = 1'b0;
            cyc(2);
            rd(8'h8c, 16'(int'(a) * 255 / 1023));
        end
        rd(8'h55, 16'h0000);
        bus(1'b1, 8'h55, 16'hffff);
        rd(8'h55, 16'h0000);
        $display("test registers done");
        do_reset('{8'h03, 8'h09, 8'h00, 8'h20, 16'h0c00, 8'h00, 8'h00});
        cyc(80);
        chk("pwm_oe_o zero boot", 16'h0000, pwm_oe_o);
        chk("ready zero boot", 16'h0000, regulator_ready_out);
        bus(1'b1, 8'hd0, 16'h0002);
        wait_ready();
        chk("pwm_oe_o after set vid", 16'h003f, pwm_oe_o);
        chk("ref_code_o after set vid", 16'h0002, ref_code_o);
        rd(8'hd4, 16'h020c);
        rd(8'hd2, 16'h0000);
        rd(8'hd1, 16'h0000);
        $display("test zero boot done");
        cyc(4);
        chk("pending reads", 16'h0000, 16'(exp_q.size()));
        summarize();
    end
endmodule : tb_multiphase_rail_phase_sequencer
`default_nettype wire
